// ### core/dtpm_pin_mux.sv
// Debug, trace, boot strap and serial controller 1 pin multiplexer
// What this block does
// - Debug port returns to JTAG after power-up or while chip reset is low.
// - Debugger selection sequence switches to serial-wire; mode-select pin becomes data.
// - Debug clock pin is JTAG clock with pull-down, or serial-wire clock.
// - JTAG drives data out on port C pin 2, takes data in on pin 3.
// - Port C pins 2,4 go GPIO on config bit 5; pin 3 also in serial-wire.
// - Async trace on port C pin 2 needs async trace, serial-wire, alternate field.
// - Packet trace data on port A pin 5 needs trace off, enable, alternate field.
// - Sync trace bit 3 on port A pin 5 needs 4-wire trace and alternate field.
// - Boot strap caught at reset release selects flash info monitor start.
// - Port B pin 1 carries serial 1 slave out or UART transmit when alternate.
// - Port B pin 2 feeds serial 1 slave in or UART receive by mode.
// - Port B pin 0 is external interrupt A input besides GPIO.
// - Sync trace clock on port B pin 0 when trace on and alternate field.
`include "dtpm_params.svh"
`default_nettype none
module dtpm_pin_mux #(
    parameter logic [3:0] ALT_CODE = `DTPM_ALT_OUT_CODE
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // Debug mode control from the debug logic
    input wire logic swd_select_i,
    input wire logic [7:0] debug_pin_config_i,
    input wire logic [15:0] port_a_high_config_i,
    input wire logic [15:0] port_b_low_config_i,
    input wire logic [15:0] port_c_low_config_i,
    input wire dtpm_pkg::dtpm_trace_cfg_t trace_cfg_i,
    input wire logic serial1_uart_mode_i,
    // Core side signals
    input wire logic test_data_out_i,
    input wire logic async_trace_out_i,
    input wire logic packet_trace_data_i,
    input wire logic sync_trace_bit3_i,
    input wire logic sync_trace_clock_i,
    input wire logic serial1_slave_out_i,
    input wire logic serial1_uart_tx_i,
    input wire logic swdio_out_i,
    input wire logic swdio_oe_i,
    // GPIO drive per pin
    input wire logic [5:0] gpio_out_i,
    input wire logic [5:0] gpio_oe_i,
    // Pins
    input wire logic debug_clk_pin_i,
    input wire logic port_a_pin5_i,
    input wire logic port_b_pin0_i,
    input wire logic port_b_pin2_i,
    input wire logic port_c_pin3_i,
    input wire logic port_c_pin4_i,
    output logic port_a_pin5_o,
    output logic port_a_pin5_oe_o,
    output logic port_b_pin0_o,
    output logic port_b_pin0_oe_o,
    output logic port_b_pin1_o,
    output logic port_b_pin1_oe_o,
    output logic port_c_pin2_o,
    output logic port_c_pin2_oe_o,
    output logic port_c_pin4_o,
    output logic port_c_pin4_oe_o,
    output logic debug_clk_pulldown_o,
    output logic pullup_en_o,
    // Core side inputs
    output logic swd_mode_o,
    output logic test_clock_in_o,
    output logic swd_clock_o,
    output logic test_data_in_o,
    output logic test_mode_select_o,
    output logic swdio_in_o,
    output logic serial1_slave_in_o,
    output logic serial1_uart_rx_o,
    output logic ext_interrupt_a_o,
    output logic flash_info_monitor_o
);
    dtpm_pkg::dtpm_dbg_mode_t mode_ff, nxt_mode;
    logic boot_ff, nxt_boot;
    logic rst_seen_ff, nxt_rst_seen;
    logic swd, gpio_cfg, a5_alt, b0_alt, b1_alt, c2_alt;
    logic pkt_on, sync3_on, async_on, tclk_on;

    function automatic logic alt_sel(input logic [3:0] field);
        alt_sel = (field == ALT_CODE);
    endfunction : alt_sel

    always_comb begin
        nxt_mode = mode_ff;
        nxt_boot = boot_ff;
        nxt_rst_seen = 1'b0;
        if (swd_select_i) begin
            nxt_mode = dtpm_pkg::DTPM_SWD;
        end
        // Strap caught on the first edge after reset release, never under reset
        if (rst_seen_ff) begin
            nxt_boot = ~port_a_pin5_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            mode_ff <= dtpm_pkg::DTPM_JTAG;
            boot_ff <= `DTPM_BOOT_RST_VAL;
            rst_seen_ff <= `DTPM_SEEN_RST_VAL;
        end else begin
            mode_ff <= nxt_mode;
            boot_ff <= nxt_boot;
            rst_seen_ff <= nxt_rst_seen;
        end
    end

    always_comb begin
        swd = (mode_ff == dtpm_pkg::DTPM_SWD);
        gpio_cfg = debug_pin_config_i[`DTPM_DBG_GPIO_BIT];
        a5_alt = alt_sel(port_a_high_config_i[`DTPM_PAH_PIN5_MSB:`DTPM_PAH_PIN5_LSB]);
        b0_alt = alt_sel(port_b_low_config_i[`DTPM_PBL_PIN0_MSB:`DTPM_PBL_PIN0_LSB]);
        b1_alt = alt_sel(port_b_low_config_i[`DTPM_PBL_PIN1_MSB:`DTPM_PBL_PIN1_LSB]);
        c2_alt = alt_sel(port_c_low_config_i[`DTPM_PCL_PIN2_MSB:`DTPM_PCL_PIN2_LSB]);
        pkt_on = !trace_cfg_i.trace_en && trace_cfg_i.pkt_trace_en && a5_alt;
        sync3_on = trace_cfg_i.trace_en && trace_cfg_i.trace_sync4 && a5_alt;
        async_on = trace_cfg_i.trace_en && trace_cfg_i.trace_async && swd && c2_alt;
        tclk_on = trace_cfg_i.trace_en && b0_alt;
    end

    always_comb begin
        // Port A pin 5
        port_a_pin5_o = pkt_on ? packet_trace_data_i :
                        sync3_on ? sync_trace_bit3_i : gpio_out_i[0];
        port_a_pin5_oe_o = pkt_on || sync3_on || gpio_oe_i[0];
        // Port B pin 0
        port_b_pin0_o = tclk_on ? sync_trace_clock_i : gpio_out_i[1];
        port_b_pin0_oe_o = tclk_on || gpio_oe_i[1];
        // Port B pin 1
        port_b_pin1_o = b1_alt ? (serial1_uart_mode_i ? serial1_uart_tx_i
                                  : serial1_slave_out_i) : gpio_out_i[2];
        port_b_pin1_oe_o = b1_alt || gpio_oe_i[2];
        // Port C pin 2: GPIO wins over debug, then trace, then JTAG data out
        if (gpio_cfg) begin
            port_c_pin2_o = gpio_out_i[3];
            port_c_pin2_oe_o = gpio_oe_i[3];
        end else if (async_on) begin
            port_c_pin2_o = async_trace_out_i;
            port_c_pin2_oe_o = 1'b1;
        end else if (!swd) begin
            port_c_pin2_o = test_data_out_i;
            port_c_pin2_oe_o = 1'b1;
        end else begin
            port_c_pin2_o = 1'b0;
            port_c_pin2_oe_o = 1'b0;
        end
        // Port C pin 4: GPIO, else serial-wire data, else JTAG mode-select input
        if (gpio_cfg) begin
            port_c_pin4_o = gpio_out_i[5];
            port_c_pin4_oe_o = gpio_oe_i[5];
        end else begin
            port_c_pin4_o = swdio_out_i;
            port_c_pin4_oe_o = swd && swdio_oe_i;
        end
        debug_clk_pulldown_o = !swd;
        pullup_en_o = !gpio_cfg;
        swd_mode_o = swd;
        test_clock_in_o = swd ? 1'b0 : debug_clk_pin_i;
        swd_clock_o = swd ? debug_clk_pin_i : 1'b0;
        // Port C pin 3 input goes to GPIO use in serial-wire mode or on bit 5
        test_data_in_o = (gpio_cfg || swd) ? 1'b1 : port_c_pin3_i;
        test_mode_select_o = (gpio_cfg || swd) ? 1'b1 : port_c_pin4_i;
        swdio_in_o = (swd && !gpio_cfg) ? port_c_pin4_i : 1'b1;
        serial1_slave_in_o = serial1_uart_mode_i ? 1'b0 : port_b_pin2_i;
        serial1_uart_rx_o = serial1_uart_mode_i ? port_b_pin2_i : 1'b1;
        ext_interrupt_a_o = port_b_pin0_i;
        flash_info_monitor_o = boot_ff;
    end

    a_mode_reset: assert property (@(posedge clk_i)
        !resetn_i |=> mode_ff == dtpm_pkg::DTPM_JTAG)
        else $error("debug mode not JTAG after reset");
    a_swd_switch: assert property (@(posedge clk_i) disable iff (!resetn_i)
        swd_select_i |=> swd_mode_o)
        else $error("serial-wire select not taken");
    // Only reset may bring the port back to JTAG
    a_mode_sticky: assert property (@(posedge clk_i) disable iff (!resetn_i)
        swd_mode_o |=> swd_mode_o)
        else $error("serial-wire mode left without reset");
    a_clk_route: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !swd_mode_o |-> test_clock_in_o == debug_clk_pin_i && debug_clk_pulldown_o)
        else $error("JTAG clock not routed");
    a_tdo_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !swd_mode_o && !gpio_cfg |->
        port_c_pin2_oe_o && port_c_pin2_o == test_data_out_i)
        else $error("JTAG data out not driven");
    a_pin3_gpio: assert property (@(posedge clk_i) disable iff (!resetn_i)
        swd_mode_o |-> test_data_in_o)
        else $error("pin 3 still feeds JTAG in serial-wire mode");
    a_pin4_gpio: assert property (@(posedge clk_i) disable iff (!resetn_i)
        gpio_cfg |-> port_c_pin4_o == gpio_out_i[5] && port_c_pin4_oe_o == gpio_oe_i[5])
        else $error("pin 4 not general I/O on config bit");
    a_trace_out: assert property (@(posedge clk_i) disable iff (!resetn_i)
        async_on && !gpio_cfg |-> port_c_pin2_o == async_trace_out_i)
        else $error("async trace not on pin 2");
    a_pkt_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        pkt_on |-> port_a_pin5_oe_o && port_a_pin5_o == packet_trace_data_i)
        else $error("packet trace not on port A pin 5");
    a_sync3_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        sync3_on |-> port_a_pin5_o == sync_trace_bit3_i)
        else $error("sync trace bit 3 not driven");
    a_boot_strap: assert property (@(posedge clk_i)
        $rose(resetn_i) |=> flash_info_monitor_o == !$past(port_a_pin5_i))
        else $error("boot strap not caught");
    a_b1_uart: assert property (@(posedge clk_i) disable iff (!resetn_i)
        b1_alt && serial1_uart_mode_i |-> port_b_pin1_o == serial1_uart_tx_i)
        else $error("UART transmit not on port B pin 1");
    a_b2_route: assert property (@(posedge clk_i) disable iff (!resetn_i)
        serial1_uart_mode_i |-> serial1_uart_rx_o == port_b_pin2_i)
        else $error("UART receive not fed");
    a_irq_a: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ext_interrupt_a_o == port_b_pin0_i)
        else $error("interrupt A not fed");
    a_tclk_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tclk_on |-> port_b_pin0_oe_o && port_b_pin0_o == sync_trace_clock_i)
        else $error("trace clock not on port B pin 0");
endmodule : dtpm_pin_mux
`default_nettype wire

// ### pkg/dtpm_params.svh
// Constants for the debug, trace and serial pin multiplexer
`ifndef DTPM_PARAMS_SVH
`define DTPM_PARAMS_SVH
`define DTPM_DBG_GPIO_BIT 5
`define DTPM_PAH_PIN5_MSB 7
`define DTPM_PAH_PIN5_LSB 4
`define DTPM_PBL_PIN0_MSB 3
`define DTPM_PBL_PIN0_LSB 0
`define DTPM_PBL_PIN1_MSB 7
`define DTPM_PBL_PIN1_LSB 4
`define DTPM_PCL_PIN2_MSB 11
`define DTPM_PCL_PIN2_LSB 8
`define DTPM_ALT_OUT_CODE 4'h9
`define DTPM_BOOT_RST_VAL 1'b0
`define DTPM_SEEN_RST_VAL 1'b1
`endif

// ### pkg/dtpm_pkg.sv
// Types for the debug, trace and serial pin multiplexer
`default_nettype none
package dtpm_pkg;
    typedef enum logic {
        DTPM_JTAG,
        DTPM_SWD
    } dtpm_dbg_mode_t;

    typedef struct packed {
        logic trace_en;
        logic trace_async;
        logic trace_sync4;
        logic pkt_trace_en;
    } dtpm_trace_cfg_t;

    typedef struct packed {
        logic i;
        logic o;
        logic oe;
    } dtpm_pin_t;
endpackage : dtpm_pkg
`default_nettype wire

// ### test/dtpm_host_model.sv
// Behavioural debugger and serial host driving the multiplexer pins
`default_nettype none
module dtpm_host_model (
    // Bench requests
    input wire logic clk_i,
    input wire logic strap_on_i,
    input wire logic swd_seq_i,
    // Pin levels
    output logic tck_o,
    output logic tdi_o,
    output logic tms_o,
    output logic rx_o,
    output logic strap_n_o,
    output logic swd_select_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt = 4'h0;
    // Every counter-driven level changes often, so a stale copy is never taken for a live one
    always @(posedge clk_i) cnt <= cnt + 4'h1;
    assign tck_o = cnt[0];
    assign tdi_o = cnt[1];
    assign tms_o = cnt[2];
    assign rx_o = cnt[3];
    assign strap_n_o = ~strap_on_i;
    assign swd_select_o = swd_seq_i;
endmodule : dtpm_host_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the debug, trace and serial pin multiplexer
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_n = 1'b0;
    logic seq = 1'b0;
    logic strap = 1'b1;
    logic uart = 1'b0;
    logic [7:0] dcfg = 8'h00;
    logic [15:0] pa = 16'h0000;
    logic [15:0] pb = 16'h0000;
    logic [15:0] pc = 16'h0000;
    logic [8:0] co = 9'h000;
    logic [5:0] go = 6'h00;
    logic [5:0] ge = 6'h00;
    dtpm_pkg::dtpm_trace_cfg_t tc = '0;
    logic tck, tdi, tms, rx, sn, sel, c4, a5;
    logic a5o, a5e, b0o, b0e, b1o, b1e, c2o, c2e, c4o, c4e, pd, pu;
    logic swd, jck, sck, jdi, jms, sdi, sin, urx, irq, fim;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    assign c4 = c4e ? c4o : tms;
    assign a5 = a5e ? a5o : sn;
    dtpm_host_model dtpm_host_model_i (.clk_i(clk_i), .strap_on_i(strap), .swd_seq_i(seq),
        .tck_o(tck), .tdi_o(tdi), .tms_o(tms), .rx_o(rx), .strap_n_o(sn), .swd_select_o(sel));
    dtpm_pin_mux dtpm_pin_mux_i (.clk_i(clk_i), .resetn_i(rst_n), .swd_select_i(sel),
        .debug_pin_config_i(dcfg), .port_a_high_config_i(pa), .port_b_low_config_i(pb),
        .port_c_low_config_i(pc), .trace_cfg_i(tc), .serial1_uart_mode_i(uart),
        .test_data_out_i(co[0]), .async_trace_out_i(co[1]), .packet_trace_data_i(co[2]),
        .sync_trace_bit3_i(co[3]), .sync_trace_clock_i(co[4]), .serial1_slave_out_i(co[5]),
        .serial1_uart_tx_i(co[6]), .swdio_out_i(co[7]), .swdio_oe_i(co[8]),
        .gpio_out_i(go), .gpio_oe_i(ge), .debug_clk_pin_i(tck), .port_a_pin5_i(a5),
        .port_b_pin0_i(tdi), .port_b_pin2_i(rx), .port_c_pin3_i(tdi), .port_c_pin4_i(c4),
        .port_a_pin5_o(a5o), .port_a_pin5_oe_o(a5e), .port_b_pin0_o(b0o), .port_b_pin0_oe_o(b0e),
        .port_b_pin1_o(b1o), .port_b_pin1_oe_o(b1e), .port_c_pin2_o(c2o), .port_c_pin2_oe_o(c2e),
        .port_c_pin4_o(c4o), .port_c_pin4_oe_o(c4e), .debug_clk_pulldown_o(pd),
        .pullup_en_o(pu), .swd_mode_o(swd), .test_clock_in_o(jck), .swd_clock_o(sck),
        .test_data_in_o(jdi), .test_mode_select_o(jms), .swdio_in_o(sdi),
        .serial1_slave_in_o(sin), .serial1_uart_rx_o(urx), .ext_interrupt_a_o(irq),
        .flash_info_monitor_o(fim));
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : tick
    task automatic finish_test();
        if (mismatches == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : finish_test
    task automatic do_reset(input logic s);
        rst_n = 1'b0;
        strap = s;
        tick(5);
        rst_n = 1'b1;
        tick(1);
    endtask : do_reset
    initial forever #25 clk_i = ~clk_i;
    // Ceiling well above the few dozen cycles the sequence needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            finish_test();
        end
    end
    initial begin
        do_reset(1'b1);
        chk(fim, 8'h01);
        chk({swd, pd, pu}, 8'h03);
        for (int v = 0; v < 2; v++) begin
            co[0] = v[0];
            tick(1);
            chk({c2o, c2e, jdi, jms, jck}, {v[0], 1'b1, tdi, tms, tck});
            chk({jck, pd}, {tck, 1'b1});
        end
        dcfg = 8'h20;
        go = 6'h28;
        ge = 6'h28;
        tick(1);
        chk({c2o, c2e, c4o, c4e, pu}, 8'h1E);
        chk({jdi, jms}, 8'h03);
        dcfg = 8'h00;
        pa = 16'h0090;
        pb = 16'h0099;
        // Trace bit 3 differs from packet data and trace clock so a swapped source shows
        for (int v = 0; v < 2; v++) begin
            tc = 4'b0001;
            co[4:2] = {v[0], ~v[0], v[0]};
            tick(1);
            chk({a5o, a5e}, {v[0], 1'b1});
            tc = 4'b1010;
            tick(1);
            chk({a5o, a5e}, {~v[0], 1'b1});
            chk({b0o, b0e}, {v[0], 1'b1});
            uart = v[0];
            co[6:5] = v[0] ? 2'b10 : 2'b01;
            tick(1);
            chk({b1o, b1e}, 8'h03);
            chk({sin, urx}, v[0] ? {1'b0, rx} : {rx, 1'b1});
        end
        pa = 16'h0080;
        pb = 16'h0000;
        ge = 6'h00;
        tick(1);
        chk({a5e, b0e, irq}, {2'b00, tdi});
        seq = 1'b1;
        tick(1);
        seq = 1'b0;
        // JTAG data out held low so async trace on pin 2 is told apart from it
        co = 9'h182;
        pc = 16'h0900;
        tc = 4'b1100;
        tick(3);
        chk({swd, pd, sck, sdi}, {2'b10, tck, c4});
        chk({c4o, c4e, jdi}, 8'h07);
        chk({c2o, c2e}, 8'h03);
        tc = 4'b0000;
        tick(1);
        chk({c2o, c2e}, 8'h00);
        do_reset(1'b0);
        chk({fim, swd}, 8'h00);
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
